// ---- rtl/uatx_top.v ----
// Contract
// (RULE1) Line idles at mark; start bit is space, stop bit is mark.
// (RULE2) Frame: one start, eight or nine data bits, one or more stops.
// (RULE3) Every bit lasts exactly one baud period.
// (RULE4) Data bits go out least significant bit first.
// (RULE5) One shared 8- or 16-bit divider sets the common baud rate.
// (RULE6) No hardware parity; software supplies it in the ninth bit.
// (RULE7) Transmit active only with enable set, sync clear, port enabled.
// (RULE8) Port enable forces the transmit pin to output; code forces it only while transmit enable is also set.
// (RULE9) Disabled transmitter releases the pin for general use.
// (RULE10) Write with empty shifter loads it at once and starts frame.
// (RULE11) Busy shifter: hold character until stop done, then load quickly.
// (RULE12) Polarity bit one inverts idle and data in async mode only; code inverts whenever port and transmit enable are set, sync bit unchecked.
// (RULE13) Buffer-empty flag set when enabled and holding buffer empty.
// (RULE14) Buffer-empty flag sets as soon as transmit enable sets.
// (RULE15) Buffer-empty flag valid by second instruction cycle after write.
// (RULE16) Flag ignores interrupt enable; request needs all three enables.
// (RULE17) Software sets interrupt enable only while data remains.
// (RULE18) Shift-empty bit set when empty, clear from load until done.
// (RULE19) Nine-bit mode sends stored ninth bit; software writes it first.
// (RULE20) Software programs divider, port, mode, enable, then loads data.
// (RULE21) Ninth bit follows data bit seven, before the stop bit.
`include "uatx_consts.vh"
module uatx_top (
  input  wire       core_clk,
  input  wire       arst_n,
  input  wire [2:0] regAddr,
  input  wire [7:0] regWdata,
  input  wire       regWrite,
  input  wire       regRead,
  output reg  [7:0] regRdata_r,
  input  wire       gpioOut,
  input  wire       gpioOe,
  output reg        txPinOut_r,
  output reg        txPinOe_r,
  output reg        txIrq_r,
  output reg        bufEmpty_r,
  output reg        shiftEmpty_r
);
  reg  [7:0] txsc_r;
  reg  [7:0] rxsc_r;
  reg  [7:0] baudc_r;
  reg  [7:0] divLo_r;
  reg  [7:0] divHi_r;
  reg  [2:0] inten_r;
  reg  [8:0] hold_r;
  reg        holdFull_r;
  reg  [1:0] icycCnt_r;
  reg        flagEmpty_r;
  wire       bitTick;
  wire       lineBit;
  wire       busy;
  wire       txOn;
  wire       portOn;
  wire       nineBit;
  wire       load;
  wire       icycTick;
  wire [7:0] statusView;

  function wr_hit;
    input [2:0] addr;
    input [2:0] target;
    input       strobe;
    begin
      wr_hit = strobe && (addr == target);
    end
  endfunction

  assign portOn  = rxsc_r[`UATX_RXSC_SERIAL_PORT_ENABLE_BIT];
  assign txOn    = txsc_r[`UATX_TXSC_XMIT] && !txsc_r[`UATX_TXSC_SYNC] && portOn; // RULE7
  assign nineBit = txsc_r[`UATX_TXSC_NINE];
  assign load    = holdFull_r && !busy && txOn; // RULE10 RULE11
  assign icycTick = (icycCnt_r == `UATX_ICYC_CLKS);

  uatx_baud_gen u_baud (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .run       (txOn && busy),
    .wideSel   (baudc_r[`UATX_BAUDC_WIDE]),
    .highSpeed (txsc_r[`UATX_TXSC_HSPD]),
    .divisor   ({divHi_r, divLo_r}),
    .bitTick_r (bitTick)
  ); // RULE3 RULE5

  uatx_shifter u_shift (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .enable    (txOn),
    .bitTick   (bitTick),
    .load      (load),
    .loadData  (hold_r),
    .nineBit   (nineBit),
    .lineBit_r (lineBit),
    .busy_r    (busy)
  ); // RULE1 RULE2 RULE4 RULE6 RULE19 RULE21

  // Registers written by software
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      txsc_r  <= `UATX_RST_BYTE;
      rxsc_r  <= `UATX_RST_BYTE;
      baudc_r <= `UATX_RST_BYTE;
      divLo_r <= `UATX_RST_BYTE;
      divHi_r <= `UATX_RST_BYTE;
      inten_r <= 3'h0;
    end else begin
      if (wr_hit(regAddr, `UATX_ADDR_TXSC, regWrite))
        txsc_r <= regWdata;
      if (wr_hit(regAddr, `UATX_ADDR_RXSC, regWrite))
        rxsc_r <= regWdata;
      if (wr_hit(regAddr, `UATX_ADDR_BAUDC, regWrite))
        baudc_r <= regWdata;
      if (wr_hit(regAddr, `UATX_ADDR_DIVL, regWrite))
        divLo_r <= regWdata;
      if (wr_hit(regAddr, `UATX_ADDR_DIVH, regWrite))
        divHi_r <= regWdata;
      if (wr_hit(regAddr, `UATX_ADDR_INTEN, regWrite))
        inten_r <= regWdata[2:0];
    end
  end

  // Holding buffer: ninth bit captured from control at write time
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_r     <= 9'h000;
      holdFull_r <= 1'b0;
    end else if (!txOn) begin
      holdFull_r <= 1'b0;
    end else if (wr_hit(regAddr, `UATX_ADDR_HOLD, regWrite)) begin
      hold_r     <= {txsc_r[`UATX_TXSC_D9], regWdata}; // RULE19
      holdFull_r <= 1'b1;
    end else if (load) begin
      holdFull_r <= 1'b0; // RULE10 RULE11
    end
  end

  // Instruction-cycle tick paces the buffer-empty flag clear; setting a clear flag is immediate
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n)
      icycCnt_r <= 2'h0;
    else
      icycCnt_r <= icycCnt_r + 2'h1;
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n)
      flagEmpty_r <= 1'b0;
    else if (!txOn)
      flagEmpty_r <= 1'b0;
    else if (!flagEmpty_r && !holdFull_r)
      flagEmpty_r <= 1'b1; // RULE14
    else if (icycTick)
      flagEmpty_r <= !(holdFull_r && busy); // RULE13 RULE15
  end

  assign statusView = {txsc_r[7:2], !busy, txsc_r[0]};

  // Outputs and read port
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata_r   <= 8'h00;
      txPinOut_r   <= 1'b1;
      txPinOe_r    <= 1'b0;
      txIrq_r      <= 1'b0;
      bufEmpty_r   <= 1'b0;
      shiftEmpty_r <= 1'b1;
    end else begin
      bufEmpty_r   <= flagEmpty_r;
      shiftEmpty_r <= !busy; // RULE18
      txIrq_r      <= flagEmpty_r && (&inten_r); // RULE16
      if (portOn && txsc_r[`UATX_TXSC_XMIT]) begin
        txPinOe_r  <= 1'b1; // RULE8
        txPinOut_r <= lineBit ^ baudc_r[`UATX_BAUDC_POL]; // RULE12
      end else begin
        txPinOe_r  <= gpioOe; // RULE9
        txPinOut_r <= gpioOut;
      end
      if (regRead) begin
        case (regAddr)
          `UATX_ADDR_TXSC:  regRdata_r <= statusView;
          `UATX_ADDR_RXSC:  regRdata_r <= rxsc_r;
          `UATX_ADDR_BAUDC: regRdata_r <= baudc_r;
          `UATX_ADDR_DIVL:  regRdata_r <= divLo_r;
          `UATX_ADDR_DIVH:  regRdata_r <= divHi_r;
          `UATX_ADDR_INTEN: regRdata_r <= {4'h0, flagEmpty_r, inten_r};
          default:          regRdata_r <= 8'h00;
        endcase
      end else begin
        regRdata_r <= 8'h00;
      end
    end
  end
endmodule

// ---- rtl/uatx_consts.vh ----
`ifndef UATX_CONSTS_VH
`define UATX_CONSTS_VH
// Register indices on the plain register port
`define UATX_ADDR_TXSC      3'h0
`define UATX_ADDR_RXSC      3'h1
`define UATX_ADDR_BAUDC     3'h2
`define UATX_ADDR_DIVL      3'h3
`define UATX_ADDR_DIVH      3'h4
`define UATX_ADDR_HOLD      3'h5
`define UATX_ADDR_INTEN     3'h6
// transmit_status_control fields
`define UATX_TXSC_NINE      6
`define UATX_TXSC_XMIT      5
`define UATX_TXSC_SYNC      4
`define UATX_TXSC_HSPD      2
`define UATX_TXSC_EMPTY     1
`define UATX_TXSC_D9        0
// receive_status_control fields
`define UATX_RXSC_SERIAL_PORT_ENABLE_BIT      7
// baud_control fields
`define UATX_BAUDC_POL      4
`define UATX_BAUDC_WIDE     3
// Interrupt enable register fields
`define UATX_INTEN_GLOB     2
`define UATX_INTEN_PERI     1
`define UATX_INTEN_XMIT     0
// Reset values
`define UATX_RST_TXSC       8'h02
`define UATX_RST_BYTE       8'h00
// Instruction cycle as system clocks (four oscillator periods)
`define UATX_ICYC_CLKS      2'h3
// Baud divider prescale: low speed 8-bit 64, high or 16-bit 16, both 4
`define UATX_PRE_64         6'h3F
`define UATX_PRE_16         6'h0F
`define UATX_PRE_4          6'h03
// Frame lengths in bits including start and stop
`define UATX_FRAME_8        4'hA
`define UATX_FRAME_9        4'hB
`endif

// ---- rtl/uatx_baud_gen.v ----
`include "uatx_consts.vh"
module uatx_baud_gen (
  input  wire        core_clk,
  input  wire        arst_n,
  input  wire        run,
  input  wire        wideSel,
  input  wire        highSpeed,
  input  wire [15:0] divisor,
  output reg         bitTick_r
);
  reg [5:0]  preCnt_r;
  reg [15:0] divCnt_r;
  wire [5:0]  preTop = (wideSel && highSpeed) ? `UATX_PRE_4 :
                       (wideSel || highSpeed) ? `UATX_PRE_16 : `UATX_PRE_64;
  wire [15:0] divTop = wideSel ? divisor : {8'h00, divisor[7:0]};
  wire        preWrap = (preCnt_r >= preTop);
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      preCnt_r  <= 6'h00;
      divCnt_r  <= 16'h0000;
      bitTick_r <= 1'b0;
    end else if (!run) begin
      // One count in: the start bit leaves on the load edge, the same edge run rises, a clock before run is first sampled high
      preCnt_r  <= 6'h01;
      divCnt_r  <= 16'h0000;
      bitTick_r <= 1'b0;
    end else begin
      bitTick_r <= 1'b0;
      if (preWrap) begin
        preCnt_r <= 6'h00;
        if (divCnt_r >= divTop) begin
          divCnt_r  <= 16'h0000;
          bitTick_r <= 1'b1;
        end else begin
          divCnt_r <= divCnt_r + 16'h0001;
        end
      end else begin
        preCnt_r <= preCnt_r + 6'h01;
      end
    end
  end
endmodule

// ---- rtl/uatx_shifter.v ----
`include "uatx_consts.vh"
module uatx_shifter (
  input  wire       core_clk,
  input  wire       arst_n,
  input  wire       enable,
  input  wire       bitTick,
  input  wire       load,
  input  wire [8:0] loadData,
  input  wire       nineBit,
  output reg        lineBit_r,
  output reg        busy_r
);
  reg [9:0] shift_r;
  reg [3:0] bitsLeft_r;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_r    <= 10'h3FF;
      bitsLeft_r <= 4'h0;
      lineBit_r  <= 1'b1;
      busy_r     <= 1'b0;
    end else if (!enable) begin
      shift_r    <= 10'h3FF;
      bitsLeft_r <= 4'h0;
      lineBit_r  <= 1'b1;
      busy_r     <= 1'b0;
    end else if (load && !busy_r) begin
      // Start bit goes out now; data follows LSb first, then stop
      lineBit_r  <= 1'b0;
      shift_r    <= nineBit ? {1'b1, loadData} : {2'b11, loadData[7:0]};
      bitsLeft_r <= nineBit ? (`UATX_FRAME_9 - 4'h1) : (`UATX_FRAME_8 - 4'h1);
      busy_r     <= 1'b1;
    end else if (busy_r && bitTick) begin
      if (bitsLeft_r == 4'h0) begin
        busy_r    <= 1'b0;
        lineBit_r <= 1'b1;
      end else begin
        lineBit_r  <= shift_r[0];
        shift_r    <= {1'b1, shift_r[9:1]};
        bitsLeft_r <= bitsLeft_r - 4'h1;
      end
    end
  end
endmodule

// ---- verification/uatx_top_chk.sv ----
module uatx_top_chk (
  input wire logic       core_clk,
  input wire logic       arst_n,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regRdata_r,
  input wire logic       gpioOut,
  input wire logic       gpioOe,
  input wire logic       txPinOut_r,
  input wire logic       txPinOe_r,
  input wire logic       txIrq_r,
  input wire logic       bufEmpty_r,
  input wire logic       shiftEmpty_r
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] busyLen_r;
  // Saturating count of cycles the shifter has been busy
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) busyLen_r <= 8'h00;
    else if (shiftEmpty_r) busyLen_r <= 8'h00;
    else if (busyLen_r != 8'hFF) busyLen_r <= busyLen_r + 8'h01;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  a_read_quiet: assert property (!$past(regRead) |-> regRdata_r == 8'h00)
    else $error("read data outside read slot");
  a_hold_wo: assert property ($past(regRead) && ($past(regAddr) == 3'h5 || $past(regAddr) == 3'h7)
    |-> regRdata_r == 8'h00) else $error("write-only or unmapped read nonzero");
  a_irq_flag: assert property (txIrq_r |-> bufEmpty_r || $past(bufEmpty_r))
    else $error("irq without empty flag");
  a_bit_hold: assert property (txPinOe_r && $past(txPinOe_r) && !shiftEmpty_r && $changed(txPinOut_r)
    |=> $stable(txPinOut_r) [*3]) else $error("bit shorter than four clocks");
  a_frame_len: assert property ($rose(shiftEmpty_r) |-> busyLen_r >= 8'h26)
    else $error("frame too short");
  a_pin_driven: assert property (!shiftEmpty_r && $past(!shiftEmpty_r) |-> txPinOe_r)
    else $error("pin not driven during frame");
  a_flag_on_en: assert property (regWrite && regAddr == 3'h0 && regWdata[5] && !regWdata[4]
    && shiftEmpty_r |-> ##[1:8] bufEmpty_r) else $error("flag not set on enable");
  a_flag_clear: assert property (regWrite && regAddr == 3'h5 && !shiftEmpty_r && bufEmpty_r
    |-> ##[1:8] !bufEmpty_r) else $error("flag not cleared on queued write");
  c_frame: cover property ($rose(shiftEmpty_r));
  c_irq: cover property ($rose(txIrq_r));
  c_read: cover property ($past(regRead) && regRdata_r != 8'h00);
endmodule
bind uatx_top uatx_top_chk chk (.core_clk(core_clk), .arst_n(arst_n), .regAddr(regAddr),
  .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata_r(regRdata_r),
  .gpioOut(gpioOut), .gpioOe(gpioOe), .txPinOut_r(txPinOut_r), .txPinOe_r(txPinOe_r),
  .txIrq_r(txIrq_r), .bufEmpty_r(bufEmpty_r), .shiftEmpty_r(shiftEmpty_r));

// ---- verification/uatx_rx_model.sv ----
module uatx_rx_model #(parameter int BITCLK = 4) (
  input  wire logic       core_clk,
  input  wire logic       line,
  input  wire logic       inv,
  input  wire logic       nine,
  input  wire logic       listen,
  output logic      [8:0] rxData,
  output logic            stopOk,
  output logic      [7:0] rxCount
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rxData = 9'h000;
    stopOk = 1'b0;
    rxCount = 8'h00;
    forever begin
      @(posedge core_clk);
      if (listen && (line ^ inv) === 1'b0) begin
        repeat (BITCLK / 2) @(posedge core_clk);
        rxData = 9'h000;
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
          repeat (BITCLK) @(posedge core_clk);
          rxData[i] = line ^ inv;
        end
        repeat (BITCLK) @(posedge core_clk);
        stopOk = line ^ inv;
        rxCount <= rxCount + 8'h01;
      end
    end
  end
endmodule

// ---- verification/uatx_top_bench.sv ----
module uatx_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWdata = 8'h00;
  logic       regWrite = 1'b0;
  logic       regRead = 1'b0;
  logic       gpioOut = 1'b0;
  logic       gpioOe = 1'b1;
  logic       inv = 1'b0;
  logic       nine = 1'b0;
  logic       listen = 1'b0;
  wire  [7:0] regRdata_r;
  wire        txPinOut_r, txPinOe_r, txIrq_r, bufEmpty_r, shiftEmpty_r, stopOk;
  wire  [8:0] rxData;
  wire  [7:0] rxCount;
  int         err_total = 0;
  int         cmp_count = 0;
  int         gap;
  initial forever #2 core_clk = ~core_clk;
  uatx_top dut (.core_clk(core_clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata_r(regRdata_r), .gpioOut(gpioOut),
    .gpioOe(gpioOe), .txPinOut_r(txPinOut_r), .txPinOe_r(txPinOe_r), .txIrq_r(txIrq_r),
    .bufEmpty_r(bufEmpty_r), .shiftEmpty_r(shiftEmpty_r));
  // Released line rests high through its pull-up
  uatx_rx_model rx (.core_clk(core_clk), .line(txPinOe_r ? txPinOut_r : 1'b1), .inv(inv),
    .nine(nine), .listen(listen), .rxData(rxData), .stopOk(stopOk), .rxCount(rxCount));
  task automatic report_and_stop();
    $display("compares %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    @(posedge core_clk);
    chk({1'b0, regRdata_r}, {1'b0, exp});
  endtask
  task automatic wait_rx(input logic [7:0] n);
    gap = 0;
    while (rxCount !== n) begin
      @(posedge core_clk);
      gap++;
      if (gap > 300) begin
        err_total++;
        $display("ERROR %0t: receiver timeout", $time);
        report_and_stop();
      end
    end
  endtask
  task automatic wait_shift(input logic lvl, input int lim);
    gap = 0;
    while (shiftEmpty_r !== lvl) begin
      @(posedge core_clk);
      gap++;
      if (gap > lim) begin
        err_total++;
        $display("ERROR %0t: shifter timeout", $time);
        report_and_stop();
      end
    end
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    for (int a = 0; a < 8; a++) rd(a[2:0], (a == 0) ? 8'h02 : 8'h00);
    chk(txPinOe_r, 1'b1);
    chk(txPinOut_r, 1'b0);
    gpioOut <= 1'b1;
    gpioOe <= 1'b0;
    wr(3'h3, 8'h00);
    listen <= 1'b1;
    wr(3'h4, 8'h00);
    wr(3'h2, 8'h08);
    wr(3'h1, 8'h80);
    wr(3'h0, 8'h34);
    wr(3'h5, 8'h55);
    cyc(60);
    chk(rxCount, 8'h00);
    chk(shiftEmpty_r, 1'b1);
    wr(3'h0, 8'h24);
    cyc(8);
    chk(txPinOe_r, 1'b1);
    chk(txPinOut_r, 1'b1);
    chk(bufEmpty_r, 1'b1);
    wr(3'h5, 8'hA5);
    cyc(10);
    chk(shiftEmpty_r, 1'b0);
    wr(3'h5, 8'h3C);
    cyc(10);
    chk(bufEmpty_r, 1'b0);
    rd(3'h0, 8'h24);
    wait_rx(8'h01);
    chk(rxData, 9'h0A5);
    wait_rx(8'h02);
    chk(rxData, 9'h03C);
    chk(gap >= 40 && gap <= 44, 1'b1);
    chk(stopOk, 1'b1);
    wr(3'h6, 8'h07);
    cyc(4);
    chk(txIrq_r, 1'b1);
    rd(3'h6, 8'h0F);
    wr(3'h6, 8'h06);
    cyc(4);
    chk(txIrq_r, 1'b0);
    chk(bufEmpty_r, 1'b1);
    listen <= 1'b0;
    wr(3'h2, 8'h18);
    cyc(8);
    chk(txPinOut_r, 1'b0);
    inv <= 1'b1;
    nine <= 1'b1;
    listen <= 1'b1;
    wr(3'h0, 8'h65);
    wr(3'h5, 8'h81);
    wait_rx(8'h03);
    chk(rxData, 9'h181);
    chk(stopOk, 1'b1);
    listen <= 1'b0;
    wr(3'h4, 8'h01);
    wr(3'h3, 8'h01);
    wr(3'h2, 8'h10);
    wr(3'h5, 8'h00);
    wait_shift(1'b0, 20);
    wait_shift(1'b1, 400);
    chk(gap == 352, 1'b1);
    wr(3'h0, 8'h61);
    wr(3'h5, 8'h00);
    wait_shift(1'b0, 20);
    wait_shift(1'b1, 1500);
    chk(gap == 1408, 1'b1);
    wr(3'h0, 8'h00);
    cyc(8);
    chk(txPinOe_r, 1'b0);
    chk(bufEmpty_r, 1'b0);
    report_and_stop();
  end
endmodule
